// ===== verilog/reset_cause_pkg.sv
// Constants, layouts and carriers for the reset-cause flag block.
// Assumes a 32-bit APB master and a core that reports reset events as pulses.
package reset_cause_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_BROWNOUT_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_POWER_CONTROL_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CPU_STATUS          = 8'h08;
  // Power-control flag positions
  localparam int BIT_STACK_OVER  = 7;
  localparam int BIT_STACK_UNDER = 6;
  localparam int BIT_PIN_RESET   = 3;
  localparam int BIT_RESET_INSTR = 2;
  localparam int BIT_POWERON     = 1;
  localparam int BIT_BROWNOUT    = 0;
  // Writable mask, bits 5 and 4 absent
  localparam logic [7:0] POWER_CONTROL_FLAGS_IMPL_MASK = 8'hcf;
  // CPU status positions
  localparam int BIT_TIMEOUT   = 4;
  localparam int BIT_POWERDOWN = 3;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'h1f;
  localparam logic [7:0] STATUS_ALU_MASK  = 8'h07;
  // Brown-out control positions
  localparam int BIT_SOFT_BOR  = 7;
  localparam int BIT_BOR_READY = 0;
  // Reset values
  localparam logic [7:0] POWER_CONTROL_FLAGS_POR_VALUE   = 8'h0c;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h18;
  localparam logic       SOFT_BOR_RESET   = 1'b1;
  // Program counter values
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
  localparam logic [15:0] PC_STEP      = 16'h0001;

  // Wake sequencing, one bit flips per step except SEQ_VECT back to SEQ_IDLE
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_VECT = 2'b11
  } seq_t;

  // Reset and wake sources, one-cycle pulses
  typedef struct packed {
    logic por;
    logic bor;
    logic pin;
    logic watchdog;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic wake_irq;
  } reset_events_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]  power_control_flags;
    logic [7:0]  status;
    logic        soft_bor;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        push_return;
    logic        cpu_reset;
    seq_t        seq;
  } state_t;
endpackage : reset_cause_pkg

// ===== verilog/reset_cause_flags.sv
// Reset-cause flag registers with APB access and program counter steering.
// Assumes events arrive as single-cycle pulses synchronous to pclk, the core
// pulses instr_done when an instruction retires, and pclk runs at 200 MHz.
//
// Behaviour
// - Power-on and brown-out update both flag registers
// - Power-on: vector zero, flags to pattern
// - Power-on clears power-on flag
// - Power-on or brown-out clears brown-out flag
// - Brown-out: vector zero, sets status flags
// - Watchdog clears timeout; in sleep resumes
// - Interrupt wake: timeout set, continue next
// - Wake with interrupts: run next, vector
// - Pin reset clears pin flag, restarts
// - Pin reset in sleep adjusts status
// - Reset instruction clears its flag only
// - Stack overflow sets flag when enabled
// - Stack underflow sets flag when enabled
// - Stack flags writable by firmware
// - Pin and instruction flags writable
// - Bits 5 and 4 read zero
// - Absent status bits read zero
`timescale 1ns/1ps
module reset_cause_flags (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire reset_cause_pkg::reset_events_t events,
  input  wire logic                          sleeping,
  input  wire logic                          stack_fault_reset_enable,
  input  wire logic                          global_interrupt_enable,
  input  wire logic                          brownout_ready,
  input  wire logic                          instr_done,
  input  wire logic [15:0]                   current_pc,
  output logic                               pc_load,
  output logic      [15:0]                   pc_value,
  output logic                               push_return,
  output logic                               cpu_reset,
  output logic                               soft_brownout_enable
);

  // Address decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      reset_cause_pkg::OFS_BROWNOUT_CONTROL:    reg_sel = 2'h1;
      reset_cause_pkg::OFS_POWER_CONTROL_FLAGS: reg_sel = 2'h2;
      reset_cause_pkg::OFS_CPU_STATUS:          reg_sel = 2'h3;
      default:                                  reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  reset_cause_pkg::state_t st_reg;
  reset_cause_pkg::state_t st_next;

  logic       setup_phase;
  logic       wr_commit;
  logic [1:0] sel;
  logic [7:0] wbyte;

  assign setup_phase = psel && !penable && !st_reg.pready;
  assign wr_commit   = psel && penable && st_reg.pready && pwrite;
  assign sel         = reg_sel(paddr);
  assign wbyte       = pwdata[7:0];

  // Next-state: bus first, then hardware events so they win on conflict
  always_comb begin
    st_next             = st_reg;
    st_next.pready      = 1'b0;
    st_next.pslverr     = 1'b0;
    st_next.pc_load     = 1'b0;
    st_next.push_return = 1'b0;
    st_next.cpu_reset   = 1'b0;

    // Registered answer, one access cycle per transfer
    if (setup_phase) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (sel == 2'h0);
      st_next.prdata  = 32'h0000_0000;
      case (sel)
        2'h1: begin
          st_next.prdata[reset_cause_pkg::BIT_SOFT_BOR]  = st_reg.soft_bor;
          st_next.prdata[reset_cause_pkg::BIT_BOR_READY] = brownout_ready;
        end
        2'h2: st_next.prdata[7:0] = st_reg.power_control_flags & reset_cause_pkg::POWER_CONTROL_FLAGS_IMPL_MASK;
        2'h3: st_next.prdata[7:0] = st_reg.status & reset_cause_pkg::STATUS_IMPL_MASK;
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end

    if (wr_commit) begin
      case (sel)
        2'h1: st_next.soft_bor = wbyte[reset_cause_pkg::BIT_SOFT_BOR];
        2'h2: st_next.power_control_flags = wbyte & reset_cause_pkg::POWER_CONTROL_FLAGS_IMPL_MASK;
        2'h3: st_next.status = wbyte & reset_cause_pkg::STATUS_IMPL_MASK;
        default: st_next.soft_bor = st_next.soft_bor;
      endcase
    end

    if (events.por) begin
      st_next.power_control_flags      = reset_cause_pkg::POWER_CONTROL_FLAGS_POR_VALUE;
      st_next.status    = reset_cause_pkg::STATUS_POR_VALUE;
      st_next.soft_bor  = reset_cause_pkg::SOFT_BOR_RESET;
      st_next.cpu_reset = 1'b1;
      st_next.pc_load   = 1'b1;
      st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
      st_next.seq       = reset_cause_pkg::SEQ_IDLE;
    end else if (events.bor) begin
      st_next.power_control_flags[reset_cause_pkg::BIT_STACK_OVER]  = 1'b0;
      st_next.power_control_flags[reset_cause_pkg::BIT_STACK_UNDER] = 1'b0;
      st_next.power_control_flags[reset_cause_pkg::BIT_PIN_RESET]   = 1'b1;
      st_next.power_control_flags[reset_cause_pkg::BIT_RESET_INSTR] = 1'b1;
      st_next.power_control_flags[reset_cause_pkg::BIT_BROWNOUT]    = 1'b0;
      st_next.status[reset_cause_pkg::BIT_TIMEOUT]   = 1'b1;
      st_next.status[reset_cause_pkg::BIT_POWERDOWN] = 1'b1;
      st_next.soft_bor  = reset_cause_pkg::SOFT_BOR_RESET;
      st_next.cpu_reset = 1'b1;
      st_next.pc_load   = 1'b1;
      st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
      st_next.seq       = reset_cause_pkg::SEQ_IDLE;
    end else if (events.pin) begin
      st_next.power_control_flags[reset_cause_pkg::BIT_PIN_RESET] = 1'b0;
      if (sleeping) begin
        // in sleep timeout set, powerdown cleared
        st_next.status[reset_cause_pkg::BIT_TIMEOUT]   = 1'b1;
        st_next.status[reset_cause_pkg::BIT_POWERDOWN] = 1'b0;
      end
      st_next.cpu_reset = 1'b1;
      st_next.pc_load   = 1'b1;
      st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
      st_next.seq       = reset_cause_pkg::SEQ_IDLE;
    end else if (events.watchdog) begin
      st_next.status[reset_cause_pkg::BIT_TIMEOUT] = 1'b0;
      st_next.pc_load = 1'b1;
      if (sleeping) begin
        st_next.status[reset_cause_pkg::BIT_POWERDOWN] = 1'b0;
        st_next.pc_value = current_pc + reset_cause_pkg::PC_STEP;
      end else begin
        st_next.cpu_reset = 1'b1;
        st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
        st_next.seq       = reset_cause_pkg::SEQ_IDLE;
      end
    end else if (events.reset_instr) begin
      st_next.power_control_flags[reset_cause_pkg::BIT_RESET_INSTR] = 1'b0;
      st_next.cpu_reset = 1'b1;
      st_next.pc_load   = 1'b1;
      st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
      st_next.seq       = reset_cause_pkg::SEQ_IDLE;
    end else if (stack_fault_reset_enable && (events.stack_over || events.stack_under)) begin
      if (events.stack_over) begin
        st_next.power_control_flags[reset_cause_pkg::BIT_STACK_OVER] = 1'b1;
      end
      if (events.stack_under) begin
        st_next.power_control_flags[reset_cause_pkg::BIT_STACK_UNDER] = 1'b1;
      end
      st_next.cpu_reset = 1'b1;
      st_next.pc_load   = 1'b1;
      st_next.pc_value  = reset_cause_pkg::RESET_VECTOR;
      st_next.seq       = reset_cause_pkg::SEQ_IDLE;
    end else if (events.wake_irq && sleeping) begin
      st_next.status[reset_cause_pkg::BIT_TIMEOUT]   = 1'b1;
      st_next.status[reset_cause_pkg::BIT_POWERDOWN] = 1'b0;
      st_next.pc_load  = 1'b1;
      st_next.pc_value = current_pc + reset_cause_pkg::PC_STEP;
      if (global_interrupt_enable) begin
        st_next.seq = reset_cause_pkg::SEQ_EXEC;
      end
    end else begin
      case (st_reg.seq)
        reset_cause_pkg::SEQ_IDLE: st_next.seq = reset_cause_pkg::SEQ_IDLE;
        reset_cause_pkg::SEQ_EXEC: begin
          if (instr_done) begin
            st_next.seq = reset_cause_pkg::SEQ_VECT;
          end
        end
        reset_cause_pkg::SEQ_VECT: begin
          st_next.push_return = 1'b1;
          st_next.pc_load     = 1'b1;
          st_next.pc_value    = reset_cause_pkg::IRQ_VECTOR;
          st_next.seq         = reset_cause_pkg::SEQ_IDLE;
        end
        default: st_next.seq = reset_cause_pkg::SEQ_IDLE;
      endcase
    end
  end

  // State register; bus reset loads the power-on register values without pulsing cpu_reset or pc_load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.power_control_flags     <= reset_cause_pkg::POWER_CONTROL_FLAGS_POR_VALUE;
      st_reg.status   <= reset_cause_pkg::STATUS_POR_VALUE;
      st_reg.soft_bor <= reset_cause_pkg::SOFT_BOR_RESET;
      st_reg.seq      <= reset_cause_pkg::SEQ_IDLE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata               = st_reg.prdata;
  assign pready               = st_reg.pready;
  assign pslverr              = st_reg.pslverr;
  assign pc_load              = st_reg.pc_load;
  assign pc_value             = st_reg.pc_value;
  assign push_return          = st_reg.push_return;
  assign cpu_reset            = st_reg.cpu_reset;
  assign soft_brownout_enable = st_reg.soft_bor;

  // Event checks sample only enabled edges, since state freezes otherwise
  a_por_pattern: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events.por |=> st_reg.power_control_flags == 8'h0c && st_reg.status[4:3] == 2'b11 && pc_value == 16'h0000)
    else $error("power-on pattern wrong");
  a_por_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events.por |=> !st_reg.power_control_flags[1])
    else $error("power-on flag not cleared");
  a_bor_keeps_por: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events.bor && !events.por |=> st_reg.power_control_flags[1] == $past(st_reg.power_control_flags[1]) && !st_reg.power_control_flags[0])
    else $error("brown-out pattern wrong");
  a_wdt_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events.watchdog && sleeping && events[7:5] == 3'b000 |=>
      pc_value == $past(current_pc) + 16'h0001 && !cpu_reset && st_reg.status[4:3] == 2'b00)
    else $error("watchdog sleep wake wrong");
  a_irq_wake_flags: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events == 8'h01 && sleeping |=> st_reg.status[4:3] == 2'b10 && st_reg.power_control_flags == $past(st_reg.power_control_flags))
    else $error("interrupt wake flags wrong");
  a_vector_after: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.seq == reset_cause_pkg::SEQ_VECT && clk_en && events == 8'h00 |=> push_return && pc_value == 16'h0004)
    else $error("interrupt vector not taken");
  a_pin_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events.pin && !events.por && !events.bor |=> !st_reg.power_control_flags[3] && cpu_reset)
    else $error("pin reset flag wrong");
  a_instr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events == 8'h08 |=> !st_reg.power_control_flags[2] && st_reg.status == $past(st_reg.status))
    else $error("reset instruction flag wrong");
  a_stack_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && events == 8'h04 && stack_fault_reset_enable |=> st_reg.power_control_flags[7] && cpu_reset)
    else $error("stack overflow flag wrong");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == 8'h04 && !pwrite |-> prdata[5:4] == 2'b00 && prdata[31:8] == 24'h0)
    else $error("unimplemented bits nonzero");
  c_por: cover property (@(posedge pclk) disable iff (!presetn) clk_en && events.por);
  c_wake_vector: cover property (@(posedge pclk) disable iff (!presetn) push_return);
  c_wdt_sleep: cover property (@(posedge pclk) disable iff (!presetn) clk_en && events.watchdog && sleeping);
  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_commit && clk_en);
endmodule : reset_cause_flags

// ===== sim/test_reset_cause_flags.sv
// Self-checking bench for the reset-cause flag block: event table, then hand tests.
// Assumes registered outputs one edge after an event; APB waits for pready, except the hand-driven collision write, which runs a fixed two edges.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_reset_cause_flags;
  typedef struct {
    logic [7:0]  ev;
    logic        slp;
    logic [7:0]  power_control_flags_pre;
    logic [7:0]  stat_pre;
    logic [7:0]  power_control_flags_exp;
    logic [7:0]  stat_exp;
    logic [15:0] pc_exp;
    logic        rst_exp;
  } row_t;
  logic                           pclk, presetn, psel, penable, pwrite;
  logic [7:0]                     paddr;
  logic [31:0]                    pwdata, prdata, rd;
  logic                           pready, pslverr, er;
  reset_cause_pkg::reset_events_t events;
  logic                           sleeping, stack_fault_reset_enable, global_interrupt_enable;
  logic                           brownout_ready, instr_done, pc_load, push_return, cpu_reset;
  logic                           soft_brownout_enable, clk_en;
  logic [15:0]                    current_pc, pc_value;
  int                             fails, num_checks;
  row_t                           rows [10];
  reset_cause_flags dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .sleeping(sleeping), .stack_fault_reset_enable(stack_fault_reset_enable),
    .global_interrupt_enable(global_interrupt_enable), .brownout_ready(brownout_ready),
    .instr_done(instr_done), .current_pc(current_pc), .pc_load(pc_load), .pc_value(pc_value),
    .push_return(push_return), .cpu_reset(cpu_reset), .soft_brownout_enable(soft_brownout_enable));
  // Free-running 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample pready at the edge itself; data taken at that same edge
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Single-cycle event pulse, outputs settled after the answering edge
  task pulse(input logic [7:0] e);
    @(posedge pclk);
    events <= reset_cause_pkg::reset_events_t'(e);
    @(posedge pclk);
    events <= '0;
    #1;
  endtask : pulse
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
  initial begin
    fails = 0; num_checks = 0; clk_en = 1'b1;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    events = '0; sleeping = 1'b0; stack_fault_reset_enable = 1'b1; global_interrupt_enable = 1'b0;
    brownout_ready = 1'b1; instr_done = 1'b0; current_pc = 16'h0120;
    // Event, sleep, presets, expected flags, program counter, core reset
    rows[0] = '{8'h80, 1'b0, 8'hcf, 8'h00, 8'h0c, 8'h18, 16'h0000, 1'b1};
    rows[1] = '{8'h40, 1'b0, 8'hcf, 8'h00, 8'h0e, 8'h18, 16'h0000, 1'b1};
    rows[2] = '{8'h20, 1'b0, 8'hcf, 8'h05, 8'hc7, 8'h05, 16'h0000, 1'b1};
    rows[3] = '{8'h20, 1'b1, 8'hcf, 8'h0d, 8'hc7, 8'h15, 16'h0000, 1'b1};
    rows[4] = '{8'h10, 1'b0, 8'hcf, 8'h1f, 8'hcf, 8'h0f, 16'h0000, 1'b1};
    rows[5] = '{8'h10, 1'b1, 8'hcf, 8'h1f, 8'hcf, 8'h07, 16'h0121, 1'b0};
    rows[6] = '{8'h08, 1'b0, 8'hcf, 8'h1f, 8'hcb, 8'h1f, 16'h0000, 1'b1};
    rows[7] = '{8'h04, 1'b0, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0000, 1'b1};
    rows[8] = '{8'h02, 1'b0, 8'h00, 8'h00, 8'h40, 8'h00, 16'h0000, 1'b1};
    rows[9] = '{8'h01, 1'b1, 8'h00, 8'h08, 8'h00, 8'h10, 16'h0121, 1'b0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Values after reset release
    apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
    `CHK("power_control_flags reset", 32'h0000000c, rd)
    apb(1'b0, reset_cause_pkg::OFS_CPU_STATUS, 32'h0);
    `CHK("status reset", 32'h00000018, rd)
    apb(1'b0, reset_cause_pkg::OFS_BROWNOUT_CONTROL, 32'h0);
    `CHK("borctl reset", 32'h00000081, rd)
    $display("test reset values done");
    // Table of reset and wake sources
    foreach (rows[i]) begin
      apb(1'b1, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, {24'h0, rows[i].power_control_flags_pre});
      apb(1'b1, reset_cause_pkg::OFS_CPU_STATUS, {24'h0, rows[i].stat_pre});
      apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
      `CHK("power_control_flags preset", {24'h0, rows[i].power_control_flags_pre}, rd)
      sleeping <= rows[i].slp;
      pulse(rows[i].ev);
      `CHK("pc_load", 1'b1, pc_load)
      `CHK("pc_value", rows[i].pc_exp, pc_value)
      `CHK("cpu_reset", rows[i].rst_exp, cpu_reset)
      sleeping <= 1'b0;
      apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
      `CHK("power_control_flags flags", {24'h0, rows[i].power_control_flags_exp}, rd)
      apb(1'b0, reset_cause_pkg::OFS_CPU_STATUS, 32'h0);
      `CHK("status flags", {24'h0, rows[i].stat_exp}, rd)
      $display("test row %0d done", i);
    end
    // Absent bits and unmapped address
    apb(1'b1, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h000000ff);
    apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
    `CHK("power_control_flags absent bits", 32'h000000cf, rd)
    apb(1'b1, reset_cause_pkg::OFS_CPU_STATUS, 32'h000000ff);
    apb(1'b0, reset_cause_pkg::OFS_CPU_STATUS, 32'h0);
    `CHK("status absent bits", 32'h0000001f, rd)
    brownout_ready <= 1'b0;
    apb(1'b1, reset_cause_pkg::OFS_BROWNOUT_CONTROL, 32'h000000ff);
    apb(1'b0, reset_cause_pkg::OFS_BROWNOUT_CONTROL, 32'h0);
    `CHK("borctl absent bits", 32'h00000080, rd)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    $display("test absent bits done");
    // Stack fault ignored while disabled, wake ignored while awake
    apb(1'b1, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h00000000);
    stack_fault_reset_enable <= 1'b0;
    pulse(8'h06);
    `CHK("pc_load disabled", 1'b0, pc_load)
    pulse(8'h01);
    `CHK("pc_load awake", 1'b0, pc_load)
    apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
    `CHK("power_control_flags disabled", 32'h00000000, rd)
    $display("test refused events done");
    // Pin reset in the same edge as a firmware write
    @(posedge pclk);
    psel <= 1'b1; pwrite <= 1'b1; paddr <= reset_cause_pkg::OFS_POWER_CONTROL_FLAGS; pwdata <= 32'h0f;
    @(posedge pclk);
    penable <= 1'b1;
    events <= reset_cause_pkg::reset_events_t'(8'h20);
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0; events <= '0;
    apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
    `CHK("power_control_flags collision", 32'h00000007, rd)
    $display("test collision done");
    // Clock enable low: an event is not taken and flags stay frozen
    clk_en <= 1'b0;
    pulse(8'h20);
    `CHK("pc_load frozen", 1'b0, pc_load)
    clk_en <= 1'b1;
    apb(1'b0, reset_cause_pkg::OFS_POWER_CONTROL_FLAGS, 32'h0);
    `CHK("power_control_flags frozen", 32'h00000007, rd)
    $display("test clock enable done");
    // Interrupt wake with interrupts enabled: next instruction, then vector
    global_interrupt_enable <= 1'b1;
    sleeping <= 1'b1;
    pulse(8'h01);
    `CHK("wake pc", 16'h0121, pc_value)
    `CHK("wake push", 1'b0, push_return)
    sleeping <= 1'b0;
    repeat (3) @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK("vector load", 1'b1, pc_load)
    `CHK("vector push", 1'b1, push_return)
    `CHK("vector pc", reset_cause_pkg::IRQ_VECTOR, pc_value)
    $display("test wake vector done");
    wrap_up();
  end
endmodule : test_reset_cause_flags
